// [core/pmc_config_core.sv]
// Configuration words and measurement sequencer of the proximity engine.
// Assumes a host writes 16-bit words by command code; the front end runs on meas_clk.
`timescale 1ns/1ps
module pmc_config_core #(
  parameter int INTEG_BASE_CYC = pmc_pkg::BASE_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        meas_clk,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_cmd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        int_clear,
  input  wire logic        sun_detect,
  input  wire logic        fe_above_high,
  input  wire logic        fe_below_low,
  output logic             ir_led_on,
  output logic             measure_busy,
  output logic             adc_double_gain,
  output logic             crosstalk_cancel_en,
  output logic      [2:0]  led_current_sel,
  output logic             prox_int
);

  pmc_pkg::pmc_state_t state_q, state_d;
  logic [15:0] tg_q, mc_q, mc_d, tick_q, tick_d, rdata_q;
  logic [2:0]  pulse_q, pulse_d, hi_cnt_q, lo_cnt_q;
  logic        req_q, req_d, ack_s1_q, ack_s2_q, ack_s3_q;
  logic        sun_s1_q, sun_s2_q;
  logic        fired_q, near_q, first_q, evt_q, sun_q;
  logic        led_q, busy_q, rvalid_q;
  logic [19:0] len_q;
  logic [3:0]  seg_q;
  logic        ack_tgl, res_high, res_low;

  // Field views of the two configuration words
  wire       powerdown    = tg_q[pmc_pkg::B_SD];
  wire       adaptive     = tg_q[pmc_pkg::B_SMART];
  wire [1:0] irq_mode     = tg_q[pmc_pkg::B_IRQ_LO +: 2];
  wire [1:0] pers         = tg_q[pmc_pkg::B_PERS_LO +: 2];
  wire       per_event    = tg_q[pmc_pkg::B_SSINT];
  wire [1:0] pulse_code   = tg_q[pmc_pkg::B_MPS_LO +: 2];
  wire [1:0] integ_code   = tg_q[pmc_pkg::B_IT_LO +: 2];
  wire       forced       = mc_q[pmc_pkg::B_MODE];
  wire       trig         = mc_q[pmc_pkg::B_TRIG];
  wire       sun_en       = mc_q[pmc_pkg::B_SP_INT];

  // Command decode
  wire       wr_tg        = reg_wr && (reg_cmd == pmc_pkg::CMD_TIMING_GAIN);
  wire       wr_mc        = reg_wr && (reg_cmd == pmc_pkg::CMD_MODE_CTRL);
  wire [15:0] rd_sel      = (reg_cmd == pmc_pkg::CMD_TIMING_GAIN) ? tg_q :
                            (reg_cmd == pmc_pkg::CMD_MODE_CTRL) ? mc_q : 16'h0000;

  // Sequencer timing
  wire [15:0] it_cyc      = 16'(INTEG_BASE_CYC * int'(pmc_pkg::pmc_times(integ_code)));
  wire        tick_last   = tick_q == it_cyc - 16'h0001;
  wire        pulse_last  = pulse_q == 3'(pmc_pkg::pmc_times(pulse_code) - 4'h1);
  wire        start_ok    = !powerdown && (forced ? trig : 1'b1);
  wire        ack_edge    = ack_s2_q ^ ack_s3_q;
  wire        done        = ack_edge && (state_q == pmc_pkg::PMC_WAIT) && !powerdown;

  // Persistence; smart mode drops the need to one after a fired event
  wire [2:0]  need        = (adaptive && fired_q) ? 3'h1 : {1'b0, pers} + 3'h1;
  wire [2:0]  hi_inc      = (hi_cnt_q == 3'h4) ? hi_cnt_q : hi_cnt_q + 3'h1;
  wire [2:0]  lo_inc      = (lo_cnt_q == 3'h4) ? lo_cnt_q : lo_cnt_q + 3'h1;
  wire        hi_evt      = done && res_high && (hi_inc >= need);
  wire        lo_evt      = done && res_low && (lo_inc >= need);

  // Interrupt selection; modes 00 and 11 keep the threshold interrupt off
  wire        irq_on      = (irq_mode == pmc_pkg::IRQ_LEVEL) || (irq_mode == pmc_pkg::IRQ_FIRST);
  wire        mode_irq    = !irq_on ? 1'b0 :
                            per_event ? evt_q :
                            (irq_mode == pmc_pkg::IRQ_LEVEL) ? near_q : first_q;

  // Hardware clears the trigger at the end of its shot, a host write in that cycle wins
  always_comb begin
    mc_d = mc_q;
    if (wr_mc) begin
      mc_d = reg_wdata & pmc_pkg::WMASK_MODE;
    end else if (done && forced) begin
      mc_d[pmc_pkg::B_TRIG] = 1'b0;
    end
  end

  // Measurement sequencer; shutdown aborts at once
  always_comb begin
    state_d = state_q;
    tick_d  = tick_q;
    pulse_d = pulse_q;
    req_d   = req_q;
    case (state_q)
      pmc_pkg::PMC_IDLE: begin
        tick_d  = 16'h0000;
        pulse_d = 3'h0;
        if (start_ok) begin
          state_d = pmc_pkg::PMC_PULSE;
        end
      end
      pmc_pkg::PMC_PULSE: begin
        if (tick_last) begin
          tick_d = 16'h0000;
          if (pulse_last) begin
            state_d = pmc_pkg::PMC_WAIT;
            req_d   = ~req_q;
          end else begin
            pulse_d = pulse_q + 3'h1;
          end
        end else begin
          tick_d = tick_q + 16'h0001;
        end
      end
      pmc_pkg::PMC_WAIT: begin
        if (ack_edge) begin
          state_d = pmc_pkg::PMC_IDLE;
        end
      end
      default: state_d = pmc_pkg::PMC_IDLE;
    endcase
    if (powerdown) begin
      state_d = pmc_pkg::PMC_IDLE;
    end
  end

  // Configuration words; the reset value leaves the sensor shut down
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tg_q <= pmc_pkg::RST_TIMING_GAIN;
      mc_q <= pmc_pkg::RST_MODE_CTRL;
    end else begin
      if (wr_tg) begin
        tg_q <= reg_wdata & pmc_pkg::WMASK_TIMING;
      end
      mc_q <= mc_d;
    end
  end

  // Sequencer registers and synchronisers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q  <= pmc_pkg::PMC_IDLE;
      tick_q   <= 16'h0000;
      pulse_q  <= 3'h0;
      req_q    <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      sun_s1_q <= 1'b0;
      sun_s2_q <= 1'b0;
      led_q    <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      tick_q   <= tick_d;
      pulse_q  <= pulse_d;
      req_q    <= req_d;
      ack_s1_q <= ack_tgl;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      sun_s1_q <= sun_detect;
      sun_s2_q <= sun_s1_q;
      led_q    <= state_d == pmc_pkg::PMC_PULSE;
      busy_q   <= state_d != pmc_pkg::PMC_IDLE;
    end
  end

  // Threshold evaluation; a set always beats a clear from int_clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hi_cnt_q <= 3'h0;
      lo_cnt_q <= 3'h0;
      fired_q  <= 1'b0;
      near_q   <= 1'b0;
      first_q  <= 1'b0;
      evt_q    <= 1'b0;
      sun_q    <= 1'b0;
    end else begin
      if (done) begin
        hi_cnt_q <= res_high ? hi_inc : 3'h0;
        lo_cnt_q <= res_low ? lo_inc : 3'h0;
      end
      fired_q <= (hi_evt || lo_evt) || (fired_q && !powerdown);
      near_q  <= hi_evt || (near_q && !lo_evt);
      first_q <= (hi_evt && irq_mode == pmc_pkg::IRQ_FIRST) || (first_q && !int_clear);
      evt_q   <= ((hi_evt || lo_evt) && per_event) || (evt_q && !int_clear);
      sun_q   <= (sun_s2_q && sun_en) || (sun_q && !int_clear);
    end
  end

  // Registered read port
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= reg_rd ? rd_sel : rdata_q;
      rvalid_q <= reg_rd;
    end
  end

  pmc_link_sampler u_sampler (
    .meas_clk      (meas_clk),
    .sys_rst       (sys_rst),
    .req_tgl       (req_q),
    .fe_above_high (fe_above_high),
    .fe_below_low  (fe_below_low),
    .ack_tgl       (ack_tgl),
    .res_high      (res_high),
    .res_low       (res_low)
  );

  assign reg_rdata           = rdata_q;
  assign reg_rvalid          = rvalid_q;
  assign ir_led_on           = led_q;
  assign measure_busy        = busy_q;
  assign adc_double_gain     = tg_q[pmc_pkg::B_HG];
  assign crosstalk_cancel_en = mc_q[pmc_pkg::B_OFFSET];
  assign led_current_sel     = mc_q[pmc_pkg::B_CURRENT_LO +: 3];
  assign prox_int            = sun_q | mode_irq;

  // Helper counters: cycles and pulse segments of the current measurement
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      len_q <= 20'h00000;
      seg_q <= 4'h0;
    end else begin
      len_q <= (state_q == pmc_pkg::PMC_PULSE) ? len_q + 20'h00001 : 20'h00000;
      seg_q <= (state_q != pmc_pkg::PMC_PULSE) ? 4'h0 : seg_q + {3'h0, tick_last};
    end
  end

  // Every check runs on the system clock and sleeps through reset
  default clocking pmc_cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_pulse_end;
    (state_q == pmc_pkg::PMC_PULSE) ##1 (state_q == pmc_pkg::PMC_WAIT);
  endsequence
  sequence s_shot_done;
    done && forced && !wr_mc;
  endsequence

  property p_level_mode;
    (irq_mode == pmc_pkg::IRQ_LEVEL && !per_event && !sun_q) |-> (prox_int == near_q);
  endproperty
  a_level_mode: assert property (p_level_mode) else $error("level mode output wrong");
  property p_first_high;
    (irq_mode == pmc_pkg::IRQ_FIRST && hi_evt && !wr_tg) |=> (first_q && prox_int);
  endproperty
  a_first_high: assert property (p_first_high) else $error("first high not raised");
  property p_smart;
    (adaptive && fired_q && done && res_high) |-> hi_evt;
  endproperty
  a_smart: assert property (p_smart) else $error("smart persistence missed event");
  property p_integ;
    s_pulse_end |-> (len_q == 20'(it_cyc * 16'(pmc_pkg::pmc_times(pulse_code))));
  endproperty
  a_integ: assert property (p_integ) else $error("measurement length wrong");
  property p_pulses;
    (state_q == pmc_pkg::PMC_PULSE && tick_last && pulse_last) |-> (seg_q + 4'h1 == pmc_pkg::pmc_times(pulse_code));
  endproperty
  a_pulses: assert property (p_pulses) else $error("pulse count wrong");
  property p_auto;
    (state_q == pmc_pkg::PMC_IDLE && !powerdown && !forced) |=> (state_q == pmc_pkg::PMC_PULSE);
  endproperty
  a_auto: assert property (p_auto) else $error("auto mode did not start");
  property p_trig_clear;
    s_shot_done |=> (!trig && state_q == pmc_pkg::PMC_IDLE) ##1 (state_q == pmc_pkg::PMC_IDLE);
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared");
  property p_sun_off;
    (!sun_en && !sun_q) |=> !sun_q;
  endproperty
  a_sun_off: assert property (p_sun_off) else $error("sun interrupt while disabled");
  property p_shutdown;
    powerdown |=> (state_q == pmc_pkg::PMC_IDLE && !ir_led_on && !measure_busy);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("measuring while shut down");
  property p_per_event;
    (per_event && irq_on && (hi_evt || lo_evt) && !wr_tg) |=> prox_int;
  endproperty
  a_per_event: assert property (p_per_event) else $error("per-event interrupt missing");

endmodule

// [core/pmc_pkg.sv]
// Shared constants for the proximity measurement configuration block.
// Assumes a 100 MHz system clock; the configuration words are 16 bits wide.
package pmc_pkg;

  // Command codes of the two configuration words
  localparam logic [7:0]  CMD_TIMING_GAIN = 8'h03;
  localparam logic [7:0]  CMD_MODE_CTRL   = 8'h04;

  // Field positions in the timing and gain word (low byte then high byte)
  localparam int          B_SD            = 0;
  localparam int          B_SMART         = 1;
  localparam int          B_IRQ_LO        = 2;
  localparam int          B_PERS_LO       = 4;
  localparam int          B_SSINT         = 8;
  localparam int          B_HG            = 10;
  localparam int          B_RSV11         = 11;
  localparam int          B_MPS_LO        = 12;
  localparam int          B_IT_LO         = 14;

  // Field positions in the mode control word
  localparam int          B_SP_INT        = 2;
  localparam int          B_OFFSET        = 3;
  localparam int          B_TRIG          = 5;
  localparam int          B_MODE          = 6;
  localparam int          B_CURRENT_LO    = 8;

  // Values after reset and writable bits; bits outside the masks stay zero, reserved bit 11 (B_RSV11) is writable
  localparam logic [15:0] RST_TIMING_GAIN = 16'h0001;
  localparam logic [15:0] RST_MODE_CTRL   = 16'h0000;
  localparam logic [15:0] WMASK_TIMING    = 16'hFDFF;
  localparam logic [15:0] WMASK_MODE      = 16'hE76C;

  // Interrupt mode encodings
  localparam logic [1:0]  IRQ_LEVEL       = 2'b01;
  localparam logic [1:0]  IRQ_FIRST       = 2'b10;

  // Base pulse length and its cycle count, rounded up
  localparam int          T_BASE_NS       = 50000;
  localparam int          SYS_CLK_NS      = 10;
  localparam int          BASE_CYC        = (T_BASE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  typedef enum logic [1:0] {
    PMC_IDLE  = 2'b00,
    PMC_PULSE = 2'b01,
    PMC_WAIT  = 2'b10
  } pmc_state_t;

  // Codes 0..3 mean 1, 2, 4 or 8 of something
  function automatic logic [3:0] pmc_times(input logic [1:0] code);
    return 4'h1 << code;
  endfunction

endpackage

// [core/pmc_link_sampler.sv]
// Front-end sampler on the measurement link clock.
// Assumes req_tgl comes from the system domain and the comparator levels are on meas_clk.
`timescale 1ns/1ps
module pmc_link_sampler (
  input  wire logic meas_clk,
  input  wire logic sys_rst,
  input  wire logic req_tgl,
  input  wire logic fe_above_high,
  input  wire logic fe_below_low,
  output logic      ack_tgl,
  output logic      res_high,
  output logic      res_low
);

  logic rst_s1_q;
  logic rst_s2_q;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic ack_q;
  logic hi_q;
  logic lo_q;
  wire  req_edge = req_s2_q ^ req_s3_q;

  // Reset is brought into this domain before it is used
  always_ff @(posedge meas_clk) begin
    rst_s1_q <= sys_rst;
    rst_s2_q <= rst_s1_q;
  end

  // Results stay frozen until the next request, so the system side reads them safely
  always_ff @(posedge meas_clk) begin
    if (rst_s2_q) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      ack_q    <= 1'b0;
      hi_q     <= 1'b0;
      lo_q     <= 1'b0;
    end else begin
      req_s1_q <= req_tgl;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      if (req_edge) begin
        hi_q  <= fe_above_high;
        lo_q  <= fe_below_low;
        ack_q <= ~ack_q;
      end
    end
  end

  assign ack_tgl  = ack_q;
  assign res_high = hi_q;
  assign res_low  = lo_q;

endmodule

// [sim/pmc_fe_model.sv]
// Front-end comparator model on the link clock.
// Assumes the bench sets the wanted reading levels; outputs change only on meas_clk.
`timescale 1ns/1ps
module pmc_fe_model (
  input  wire logic meas_clk,
  input  wire logic want_high,
  input  wire logic want_low,
  output logic      fe_above_high,
  output logic      fe_below_low
);
  // Registered so the levels really belong to the link domain
  always_ff @(posedge meas_clk) begin
    fe_above_high <= want_high;
    fe_below_low  <= want_low;
  end
endmodule

// [sim/proximity_measure_config_tb.sv]
// Self-checking bench of the configuration core with a front-end model.
// Assumes a host that writes whole 16-bit words by command code.
`timescale 1ns/1ps
module proximity_measure_config_tb;
  localparam int BASE = 4;
  logic        sys_clk = 0, sys_rst = 1, meas_clk = 0;
  logic        reg_wr = 0, reg_rd = 0, int_clear = 0, sun_detect = 0;
  logic [7:0]  reg_cmd = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, rd_v, rnd = 16'h001F;
  logic        want_high = 0, want_low = 0;
  logic [15:0] reg_rdata;
  logic [2:0]  led_current_sel;
  logic        reg_rvalid, ir_led_on, measure_busy, adc_double_gain, crosstalk_cancel_en, prox_int;
  logic        fe_above_high, fe_below_low;
  int          error_cnt = 0, comparisons = 0, n;

  // Clocks: system 10 ns, link 80 ns; link edges fall between system edges
  always #5 sys_clk = ~sys_clk;
  always #40 meas_clk = ~meas_clk;

  pmc_config_core #(.INTEG_BASE_CYC(BASE)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .meas_clk(meas_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .int_clear(int_clear), .sun_detect(sun_detect), .fe_above_high(fe_above_high),
    .fe_below_low(fe_below_low), .ir_led_on(ir_led_on), .measure_busy(measure_busy),
    .adc_double_gain(adc_double_gain), .crosstalk_cancel_en(crosstalk_cancel_en),
    .led_current_sel(led_current_sel), .prox_int(prox_int));

  pmc_fe_model fe (.meas_clk(meas_clk), .want_high(want_high), .want_low(want_low),
    .fe_above_high(fe_above_high), .fe_below_low(fe_below_low));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Timing word; bit 11 is always written as one
  function automatic logic [15:0] tw(input logic [1:0] it, mps, pers, irq, input logic ss, sm, sd);
    return {it, mps, 1'b1, 1'b0, 1'b0, ss, 2'b00, pers, irq, sm, sd};
  endfunction

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_cmd <= c;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data and its valid flag are looked at in the cycle after the strobe
  task automatic rd(input logic [7:0] c);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_cmd <= c;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 16'(reg_rvalid), 16'h0001);
    rd_v = reg_rdata;
  endtask

  // Bounded wait on the led (0) or busy (1) level
  task automatic wt(input bit w, input logic lvl);
    int i;
    i = 0;
    while (((w ? measure_busy : ir_led_on) !== lvl) && i < 3000) begin
      tick(1);
      i++;
    end
    if (i >= 3000) begin
      chk("wait", 16'h0000, 16'h0001);
      end_of_test();
    end
  endtask

  // One forced measurement; n counts lit cycles
  task automatic meas;
    wr(pmc_pkg::CMD_MODE_CTRL, 16'h0060);
    wt(0, 1);
    n = 0;
    while (ir_led_on === 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    wt(1, 0);
    tick(3);
  endtask

  task automatic clr;
    @(posedge sys_clk);
    int_clear <= 1'b1;
    @(posedge sys_clk);
    int_clear <= 1'b0;
    tick(2);
  endtask

  task automatic fe_set(input logic h, input logic l);
    @(posedge sys_clk);
    want_high <= h;
    want_low <= l;
    tick(1);
  endtask

  initial begin
    // Twelve cycles hold one link edge; the link side stretches its own reset from there
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(50);
    chk("busy_sd", 16'(measure_busy), 16'h0000);
    rd(pmc_pkg::CMD_TIMING_GAIN);
    chk("rst03", rd_v, 16'h0001);
    rd(pmc_pkg::CMD_MODE_CTRL);
    chk("rst04", rd_v, 16'h0000);
    rd(8'h05);
    chk("unmapped", rd_v, 16'h0000);
    $display("test reset done");

    // Random words while still shut down
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      wr(pmc_pkg::CMD_TIMING_GAIN, rnd | 16'h0801);
      rd(pmc_pkg::CMD_TIMING_GAIN);
      chk("rw03", rd_v, (rnd | 16'h0801) & pmc_pkg::WMASK_TIMING);
      chk("hg", 16'(adc_double_gain), 16'(rnd[10]));
      rnd = lfsr(rnd);
      wr(pmc_pkg::CMD_MODE_CTRL, rnd);
      rd(pmc_pkg::CMD_MODE_CTRL);
      chk("rw04", rd_v, rnd & pmc_pkg::WMASK_MODE);
      chk("cur", 16'(led_current_sel), 16'(rnd[10:8]));
      chk("xtalk", 16'(crosstalk_cancel_en), 16'(rnd[3]));
    end
    $display("test regs done");

    // Every integration and pulse code in forced mode
    for (int it = 0; it < 4; it++) begin
      for (int mp = 0; mp < 4; mp++) begin
        wr(pmc_pkg::CMD_MODE_CTRL, 16'h0040);
        wr(pmc_pkg::CMD_TIMING_GAIN, tw(it, mp, 0, 0, 0, 0, 0));
        tick(20);
        chk("no_trig", 16'(ir_led_on), 16'h0000);
        meas();
        chk("lit", 16'(n), 16'((BASE << it) << mp));
        rd(pmc_pkg::CMD_MODE_CTRL);
        chk("trig_clr", rd_v, 16'h0040);
      end
    end
    $display("test timing done");

    // Interrupt modes
    wr(pmc_pkg::CMD_TIMING_GAIN, tw(0, 0, 0, 2'b01, 0, 0, 0));
    fe_set(1, 0);
    meas();
    chk("lvl_hi", 16'(prox_int), 16'h0001);
    fe_set(0, 1);
    meas();
    chk("lvl_lo", 16'(prox_int), 16'h0000);
    wr(pmc_pkg::CMD_TIMING_GAIN, tw(0, 0, 0, 2'b10, 0, 0, 0));
    fe_set(1, 0);
    meas();
    chk("first_hi", 16'(prox_int), 16'h0001);
    fe_set(0, 1);
    meas();
    chk("first_stay", 16'(prox_int), 16'h0001);
    clr();
    chk("first_clr", 16'(prox_int), 16'h0000);
    wr(pmc_pkg::CMD_TIMING_GAIN, tw(0, 0, 0, 2'b01, 1, 0, 0));
    meas();
    chk("evt_lo", 16'(prox_int), 16'h0001);
    clr();
    // Shutdown forgets earlier events, then two readings are needed once
    wr(pmc_pkg::CMD_TIMING_GAIN, tw(0, 0, 0, 0, 0, 0, 1));
    wr(pmc_pkg::CMD_TIMING_GAIN, tw(0, 0, 2'b01, 2'b10, 0, 1, 0));
    fe_set(1, 0);
    meas();
    chk("pers_1", 16'(prox_int), 16'h0000);
    meas();
    chk("pers_2", 16'(prox_int), 16'h0001);
    fe_set(0, 1);
    meas();
    clr();
    fe_set(1, 0);
    meas();
    chk("smart", 16'(prox_int), 16'h0001);
    clr();
    // Mode 11 keeps threshold events off the pin, even with the per-event bit
    wr(pmc_pkg::CMD_TIMING_GAIN, tw(0, 0, 0, 2'b11, 1, 0, 0));
    meas();
    chk("irq_off", 16'(prox_int), 16'h0000);
    clr();
    $display("test irq done");

    // Sunlight flag only when enabled
    sun_detect <= 1'b1;
    tick(8);
    chk("sun_off", 16'(prox_int), 16'h0000);
    wr(pmc_pkg::CMD_MODE_CTRL, 16'h0044);
    tick(8);
    chk("sun_on", 16'(prox_int), 16'h0001);
    sun_detect <= 1'b0;
    tick(6);
    clr();
    chk("sun_clr", 16'(prox_int), 16'h0000);
    $display("test sun done");

    // Auto mode runs untriggered; shutdown aborts it
    wr(pmc_pkg::CMD_MODE_CTRL, 16'h0000);
    wt(0, 1);
    chk("auto", 16'(measure_busy), 16'h0001);
    wr(pmc_pkg::CMD_TIMING_GAIN, tw(0, 0, 0, 0, 0, 0, 1));
    tick(3);
    chk("abort_busy", 16'(measure_busy), 16'h0000);
    chk("abort_led", 16'(ir_led_on), 16'h0000);
    $display("test auto done");
    end_of_test();
  end
endmodule
